// File: rtl/iso_link_pkg.sv
// Shared constants and types for the isolated channel pulse link.
// Assumes a single 10 MHz clock; times are converted to cycle counts here.
package iso_link_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************

  // Local oscillator period in nanoseconds.
  localparam int CLK_PERIOD_NS = 100;
  // Idle time of the input before refresh pulses are sent.
  localparam int REFRESH_IDLE_NS = 1000;
  // Silence on the receive side before the watchdog takes over.
  localparam int WATCHDOG_NS = 5000;

  // A least time rounds up, a longest time rounds down.
  localparam int REFRESH_CYC =
    (REFRESH_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WATCHDOG_CYC = WATCHDOG_NS / CLK_PERIOD_NS;

  // Counter width, wide enough for the watchdog count.
  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 6'h01;
  localparam logic [CNT_W-1:0] REFRESH_LAST = CNT_W'(REFRESH_CYC - 1);
  localparam logic [CNT_W-1:0] WATCHDOG_LAST = CNT_W'(WATCHDOG_CYC - 1);

  // ****************************************************************
  // Levels
  // ****************************************************************

  // Output level right after leaving supply lockout.
  localparam logic OUT_INIT_LEVEL = 1'h0;
  // Output level forced by the watchdog when the far side is silent.
  localparam logic OUT_WATCHDOG_LEVEL = 1'h1;

  // Operating mode of one die side.
  typedef enum logic {LINK_LOCKED, LINK_ACTIVE} link_mode_t;

endpackage : iso_link_pkg

// File: rtl/isolated_channel_pulse_link.sv
// One die side of an isolated data channel pair plus its power oscillator.
// Assumes every input but nrst and ce comes from pins or the far die and is unsynced;
// nrst is a synchronous reset, ce freezes all state while low.
//
// How it works
// - Each input edge sends one pulse, set pulse for rising, clear for falling.
// - Received set pulse drives output high, clear pulse drives it low.
// - After idle input longer than 1 us, periodic refresh pulses carry level.
// - No received pulse for 5 us forces the output to its high default.
// - Under supply lockout oscillator, pulse drivers and refresh stay idle.
// - Under supply lockout the data output is high impedance.
// - Leaving lockout, output starts low until pulses arrive from far side.
// - Once active, inputs are sampled and encoded pulses sent immediately.
// - Without regulation signal the power oscillator runs freely at full power.
// - Once a regulation signal appears, it modulates the power oscillator.
// - Far side output starts low, then follows our input within 1 us.
// - After activation our level reaches the far side within about 1 us.
// - Primary supply loss shuts converter and channels down at lockout.
// - Without power the output holds its last state until lockout or watchdog.
`timescale 1ns/1ns
`default_nettype none

module isolated_channel_pulse_link
  import iso_link_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic supply_lockout,
  input wire logic data_in,
  input wire logic rx_set_pulse,
  input wire logic rx_clr_pulse,
  input wire logic reg_ctrl_in,
  output logic tx_set_pulse,
  output logic tx_clr_pulse,
  output logic data_out,
  output logic data_out_en,
  output logic osc_run
);

  // ****************************************************************
  // State
  // ****************************************************************

  // All state lives in one record; synchroniser stages come first.
  typedef struct packed {
    logic lock_s1;
    logic lock_s2;
    logic din_s1;
    logic din_s2;
    logic rxs_s1;
    logic rxs_s2;
    logic rxc_s1;
    logic rxc_s2;
    logic pwm_s1;
    logic pwm_s2;
    link_mode_t mode;
    logic din_prev;
    logic pwm_prev;
    logic [CNT_W-1:0] refresh_cnt;
    logic [CNT_W-1:0] wd_cnt;
    logic [CNT_W-1:0] pwm_cnt;
    logic reg_seen;
    logic tx_set;
    logic tx_clr;
    logic out_level;
    logic out_en;
    logic osc;
  } link_state_t;

  link_state_t st;
  link_state_t next_st;

  // Edge and activity terms decoded from the second synchroniser stages.
  logic din_edge;
  logic rx_any;
  logic pwm_edge;

  assign din_edge = st.din_s2 != st.din_prev;
  assign rx_any = st.rxs_s2 | st.rxc_s2;
  assign pwm_edge = st.pwm_s2 != st.pwm_prev;

  // ****************************************************************
  // Next state
  // ****************************************************************

  // The first stages are read only by the second stages.
  always_comb
  begin
    next_st = st;
    next_st.lock_s1 = supply_lockout;
    next_st.lock_s2 = st.lock_s1;
    next_st.din_s1 = data_in;
    next_st.din_s2 = st.din_s1;
    next_st.rxs_s1 = rx_set_pulse;
    next_st.rxs_s2 = st.rxs_s1;
    next_st.rxc_s1 = rx_clr_pulse;
    next_st.rxc_s2 = st.rxc_s1;
    next_st.pwm_s1 = reg_ctrl_in;
    next_st.pwm_s2 = st.pwm_s1;
    next_st.tx_set = 1'h0;
    next_st.tx_clr = 1'h0;
    next_st.din_prev = st.din_s2;
    next_st.pwm_prev = st.pwm_s2;
    if (st.lock_s2)
    begin
      // Below lockout everything idles and the pin floats.
      next_st.mode = LINK_LOCKED;
      next_st.out_en = 1'h0;
      next_st.out_level = OUT_INIT_LEVEL;
      next_st.osc = 1'h0;
      next_st.reg_seen = 1'h0;
      next_st.refresh_cnt = CNT_ZERO;
      next_st.wd_cnt = CNT_ZERO;
      next_st.pwm_cnt = CNT_ZERO;
    end
    else
    begin
      unique case (st.mode)
        LINK_LOCKED:
        begin
          // Drive the low default and arm an immediate first send.
          next_st.mode = LINK_ACTIVE;
          next_st.out_en = 1'h1;
          next_st.out_level = OUT_INIT_LEVEL;
          next_st.refresh_cnt = REFRESH_LAST;
          next_st.wd_cnt = CNT_ZERO;
          next_st.pwm_cnt = CNT_ZERO;
          next_st.reg_seen = 1'h0;
          next_st.osc = 1'h1;
        end
        LINK_ACTIVE:
        begin
          // Encoder: one pulse per edge, refresh after idle.
          if (din_edge)
          begin
            next_st.tx_set = st.din_s2;
            next_st.tx_clr = ~st.din_s2;
            next_st.refresh_cnt = CNT_ZERO;
          end
          else if (st.refresh_cnt == REFRESH_LAST)
          begin
            next_st.tx_set = st.din_s2;
            next_st.tx_clr = ~st.din_s2;
            next_st.refresh_cnt = CNT_ZERO;
          end
          else
          begin
            next_st.refresh_cnt = st.refresh_cnt + CNT_ONE;
          end
          // Decoder: a bistable; a set and clear together is noise.
          if (rx_any)
          begin
            next_st.wd_cnt = CNT_ZERO;
            if (st.rxs_s2 && !st.rxc_s2)
            begin
              next_st.out_level = 1'h1;
            end
            else if (st.rxc_s2 && !st.rxs_s2)
            begin
              next_st.out_level = 1'h0;
            end
          end
          else if (st.wd_cnt == WATCHDOG_LAST)
          begin
            // Far side is presumed unpowered; counter saturates here.
            next_st.out_level = OUT_WATCHDOG_LEVEL;
          end
          else
          begin
            // Silence so far: the last received state holds.
            next_st.wd_cnt = st.wd_cnt + CNT_ONE;
          end
          // Regulation watch: lost control falls back to free run.
          if (pwm_edge)
          begin
            next_st.reg_seen = 1'h1;
            next_st.pwm_cnt = CNT_ZERO;
          end
          else if (st.pwm_cnt == WATCHDOG_LAST)
          begin
            next_st.reg_seen = 1'h0;
          end
          else
          begin
            next_st.pwm_cnt = st.pwm_cnt + CNT_ONE;
          end
          // Free run at full power until regulation appears.
          next_st.osc = next_st.reg_seen ? st.pwm_s2 : 1'h1;
        end
      endcase
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************

  // Reset puts the side in lockout with every output quiet.
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      st <= '0;
      st.mode <= LINK_LOCKED;
      st.lock_s1 <= 1'h1;
      st.lock_s2 <= 1'h1;
    end
    else if (ce)
    begin
      st <= next_st;
    end
  end

  // Every output is a flip-flop of the state record.
  assign tx_set_pulse = st.tx_set;
  assign tx_clr_pulse = st.tx_clr;
  assign data_out = st.out_level;
  assign data_out_en = st.out_en;
  assign osc_run = st.osc;

  // ****************************************************************
  // Checks
  // ****************************************************************

  // Checks are suspended while the clock enable holds the state frozen.
  default clocking chk_clk @(posedge clk);
  endclocking
  default disable iff (!nrst || !ce);

  // A quiet active cycle with the refresh counter at its last count.
  sequence refresh_due;
    st.mode == LINK_ACTIVE && !st.lock_s2 && !din_edge &&
      st.refresh_cnt == REFRESH_LAST;
  endsequence

  // A silent active cycle with the watchdog at its last count.
  sequence watchdog_due;
    st.mode == LINK_ACTIVE && !st.lock_s2 && !rx_any &&
      st.wd_cnt == WATCHDOG_LAST;
  endsequence

  // Leaving lockout: the release is seen while still locked.
  sequence lockout_release;
    st.mode == LINK_LOCKED && !st.lock_s2;
  endsequence

  chk_tx_rise_pulse: assert property (
    st.mode == LINK_ACTIVE && !st.lock_s2 && st.din_s2 && !st.din_prev
    |=> tx_set_pulse && !tx_clr_pulse ##1 !tx_set_pulse)
    else $error("rising edge did not give one set pulse");

  chk_tx_fall_pulse: assert property (
    st.mode == LINK_ACTIVE && !st.lock_s2 && !st.din_s2 && st.din_prev
    |=> tx_clr_pulse && !tx_set_pulse ##1 !tx_clr_pulse)
    else $error("falling edge did not give one clear pulse");

  chk_decoder_set: assert property (
    st.mode == LINK_ACTIVE && !st.lock_s2 && st.rxs_s2 && !st.rxc_s2
    |=> data_out && data_out_en)
    else $error("set pulse did not raise the output");

  chk_decoder_clear: assert property (
    st.mode == LINK_ACTIVE && !st.lock_s2 && st.rxc_s2 && !st.rxs_s2
    |=> !data_out && data_out_en)
    else $error("clear pulse did not lower the output");

  chk_refresh_level: assert property (
    refresh_due |=> tx_set_pulse == $past(st.din_s2) &&
      tx_clr_pulse != $past(st.din_s2))
    else $error("refresh pulse missing or of wrong polarity");

  chk_watchdog_high: assert property (
    watchdog_due |=> data_out == OUT_WATCHDOG_LEVEL)
    else $error("watchdog did not force the default level");

  chk_lockout_idle: assert property (
    st.lock_s2 |=> !osc_run && !tx_set_pulse && !tx_clr_pulse)
    else $error("activity during supply lockout");

  chk_lockout_float: assert property (
    st.lock_s2 |=> !data_out_en)
    else $error("output driven during supply lockout");

  chk_start_low: assert property (
    lockout_release |=> data_out_en && data_out == OUT_INIT_LEVEL)
    else $error("output did not start at its low default");

  chk_start_send: assert property (
    lockout_release ##1 !st.lock_s2 |=> tx_set_pulse || tx_clr_pulse)
    else $error("no pulse sent right after activation");

  chk_free_run: assert property (
    !st.lock_s2 && !st.reg_seen && !pwm_edge |=> osc_run)
    else $error("oscillator not free running without regulation");

  chk_pwm_follow: assert property (
    st.mode == LINK_ACTIVE && !st.lock_s2 && st.reg_seen && !pwm_edge &&
      st.pwm_cnt != WATCHDOG_LAST
    |=> osc_run == $past(st.pwm_s2))
    else $error("oscillator does not follow the regulation signal");

endmodule : isolated_channel_pulse_link

`default_nettype wire

// File: verification/far_die_model.sv
// Behavioural model of the die across the barrier for one channel pair.
// Assumes the same clock as the block; pulses last one cycle each.
`timescale 1ns/1ns
`default_nettype none

module far_die_model
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic level,
  input wire logic silent,
  input wire logic tx_set,
  input wire logic tx_clr,
  output logic rx_set,
  output logic rx_clr,
  output logic far_level
);
  logic last;
  logic [3:0] idle;

  // ****
  // Encoder toward the block and bistable decoder of its pulses
  // ****

  // Silence stops all pulses so the block's watchdog can be exercised.
  always_ff @(posedge clk)
  begin
    rx_set <= 1'h0;
    rx_clr <= 1'h0;
    if (!nrst)
    begin
      last <= 1'h0;
      idle <= 4'h0;
      far_level <= 1'h0;
    end
    else
    begin
      if (tx_set) far_level <= 1'h1;
      else if (tx_clr) far_level <= 1'h0;
      idle <= idle + 4'h1;
      if (!silent && (level != last || idle == 4'h9))
      begin
        rx_set <= level;
        rx_clr <= !level;
        last <= level;
        idle <= 4'h0;
      end
    end
  end
endmodule : far_die_model
`default_nettype wire

// File: verification/testbench.sv
// Self-checking bench for one die side of the isolated channel.
// Assumes the far die model and the package constants.
`timescale 1ns/1ns
`default_nettype none

module testbench;
  import iso_link_pkg::*;
  typedef struct packed {logic din; logic rxl; logic far; logic dout;} row_t;
  logic clk, nrst, ce, lockout, din, rxl, silent, reg_ctrl;
  logic rxs, rxc, txs, txc, dout, dout_en, osc, far;
  int num_errors = 0;
  int num_checks = 0;
  int n_set = 0;
  int n_clr = 0;
  int cycles = 0;
  row_t rows [4] = '{4'b1010, 4'b0101, 4'b1111, 4'b0000};

  isolated_channel_pulse_link dut_u (.clk(clk), .nrst(nrst), .ce(ce),
    .supply_lockout(lockout), .data_in(din), .rx_set_pulse(rxs),
    .rx_clr_pulse(rxc), .reg_ctrl_in(reg_ctrl), .tx_set_pulse(txs),
    .tx_clr_pulse(txc), .data_out(dout), .data_out_en(dout_en),
    .osc_run(osc));
  far_die_model far_u (.clk(clk), .nrst(nrst), .level(rxl),
    .silent(silent), .tx_set(txs), .tx_clr(txc), .rx_set(rxs),
    .rx_clr(rxc), .far_level(far));

  // ****
  // Clock, pulse counters and hang guard
  // ****

  // The ceiling is far above the roughly 240 cycles that the tests take.
  initial
  begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (txs === 1'h1) n_set++;
    if (txc === 1'h1) n_clr++;
    if (cycles == 3000)
    begin
      num_errors++;
      complete_run();
    end
  end

  // Inputs move 10 ns after the edge, clear of the sampling instant.
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #10;
  endtask : tick

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic complete_run;
    if (num_errors == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : complete_run

  // ****
  // Main sequence
  // ****

  initial
  begin
    {nrst, lockout, din, rxl, silent, reg_ctrl} = 6'h00;
    ce = 1'h1;
    tick(8);
    chk({dout_en, osc}, 8'h00);
    nrst = 1'h1;
    tick(2);
    chk({dout_en, osc}, 8'h00);
    tick(1);
    chk({dout_en, dout, osc}, 8'h05);
    // Ordinary traffic both ways; each row settles within a microsecond.
    foreach (rows[i])
    begin
      din = rows[i].din;
      rxl = rows[i].rxl;
      tick(6);
      chk(far, rows[i].far);
      chk(dout, rows[i].dout);
    end
    // A static low input gives one refresh clear pulse every 10 cycles.
    {n_set, n_clr} = 0;
    tick(30);
    chk(8'(n_set), 8'h00);
    chk(8'(n_clr), 8'h03);
    // A one-cycle input pulse must still give one pulse of each kind.
    tick(9);
    {n_set, n_clr} = 0;
    din = 1'h1;
    tick(1);
    din = 1'h0;
    tick(5);
    chk(8'(n_set), 8'h01);
    chk(8'(n_clr), 8'h01);
    // The regulation signal takes over the oscillator, 3 edges late.
    reg_ctrl = 1'h1;
    tick(4);
    reg_ctrl = 1'h0;
    tick(2);
    chk(osc, 1'h1);
    tick(1);
    chk(osc, 1'h0);
    reg_ctrl = 1'h1;
    tick(3);
    chk(osc, 1'h1);
    // Far side falls silent: output holds low, then is forced high.
    silent = 1'h1;
    tick(40);
    chk(dout, 1'h0);
    tick(18);
    chk(dout, 1'h1);
    silent = 1'h0;
    tick(20);
    chk(dout, 1'h0);
    // Lockout: outputs float, oscillator stops, no pulses are sent.
    lockout = 1'h1;
    tick(2);
    chk(dout_en, 1'h1);
    tick(1);
    chk({dout_en, dout, osc}, 8'h00);
    {n_set, n_clr} = 0;
    din = 1'h1;
    tick(30);
    chk(8'(n_set + n_clr), 8'h00);
    // Mid-run reset with a good supply repeats the power-on start-up.
    {lockout, nrst} = 2'h0;
    tick(2);
    chk({dout_en, osc}, 8'h00);
    nrst = 1'h1;
    tick(3);
    chk({dout_en, dout, osc}, 8'h05);
    {n_set, n_clr} = 0;
    tick(2);
    chk(8'(n_set), 8'h01);
    // A low clock enable stalls the refresh counter, so the pulse is late.
    {n_set, n_clr} = 0;
    ce = 1'h0;
    tick(20);
    ce = 1'h1;
    tick(9);
    chk(8'(n_set + n_clr), 8'h00);
    tick(1);
    chk(8'(n_set), 8'h01);
    complete_run();
  end
endmodule : testbench
`default_nettype wire
